// *** verilog/node_status_flags.v ***
// Node status flag register with Avalon-MM register access
//
// Behaviour
// (R01) Receive-inhibited sets when a packet lands in the armed page; set after reset.
// (R02) Enable-receive command clears receive-inhibited.
// (R03) Interrupt when receive-inhibited and its mask bit are both set.
// (R04) While receive-inhibited, incoming packets are answered with a negative acknowledge.
// (R05) Bits six and five have no meaning; they read as zero here.
// (R06) Power-on flag sets on hardware or soft reset, or node ID written zero.
// (R07) Clear-flags command clears the power-on flag.
// (R08) Test bit three reads as zero in normal operation.
// (R09) Reconfiguration flag sets when the line idle timer expires after 656 us.
// (R10) Clear-flags command clears the reconfiguration flag.
// (R11) Reconfiguration with mask bit raises interrupt; host checks self-caused flag.
// (R12) Transmit-acknowledged sets on acknowledge; valid only once transmitter-available is set.
// (R13) Broadcast packets never set transmit-acknowledged.
// (R14) Enable-transmit command clears transmit-acknowledged.
// (R15) Transmitter-available sets after the last byte, or on disable-transmit command.
// (R16) After enable-transmit, transmitter-available clears when the token next arrives.
// (R17) Interrupt when transmitter-available and its mask bit are both set.
// (R18) Status register is eight bits and read-only; writes change nothing.
// (R19) Reset pattern is 1XX1_0001, undefined bits given as zero.
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`include "node_status_defines.vh"

module node_status_flags #(
   parameter IDLE_CYCLES = `IDLE_TIME_US * `CLK_MHZ
) (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Avalon-MM slave
   input  wire [3:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   input  wire [3:0]  byteenable,
   output reg  [31:0] readdata,
   output wire        waitrequest,
   output reg  [1:0]  response,
   // Receive and transmit engine events
   input  wire        receive_line_input,
   input  wire        rxPacketStored,
   input  wire        rxIncomingRequest,
   input  wire        txPacketAcked,
   input  wire        txBroadcast,
   input  wire        txLastByteSent,
   input  wire        tokenReceived,
   // Engine controls
   output reg         rxNakReply,
   output reg         rxEnabled,
   output reg         txEnabled,
   // Interrupt to host
   output reg         irq
);
   reg  [7:0]  status_q;
   reg  [7:0]  interrupt_mask_register;
   reg  [7:0]  nodeId_q;
   reg         txPending_q;
   reg         ack_q;
   reg         softReset;
   reg         clearFlags;
   reg         enRx;
   reg         enTx;
   reg         disTx;
   reg         nodeIdZero;
   wire        idleExpired;
   wire        wrLow;
   wire [7:0]  intPending;

   // Single-cycle access: the slave answers in the request cycle
   assign waitrequest = 1'b0;
   assign wrLow       = write && byteenable[0];

   // Line idle timer, held cleared while reconfiguration already flagged
   idle_timer #(
      .CYCLES     (IDLE_CYCLES)
   ) u_idle (
      .clk        (clk),
      .rst_n      (rst_n),
      .lineActive (receive_line_input),
      .enable     (!status_q[`BIT_RECON]),
      .expired    (idleExpired)
   );

   // Decode command strobes from control and node ID register writes
   always @* begin
      softReset  = wrLow && (address == `ADDR_CTRL) && writedata[`CTRL_SOFT_RESET];
      clearFlags = wrLow && (address == `ADDR_CTRL) && writedata[`CTRL_CLEAR_FLAGS];
      enRx       = wrLow && (address == `ADDR_CTRL) && writedata[`CTRL_EN_RX];
      enTx       = wrLow && (address == `ADDR_CTRL) && writedata[`CTRL_EN_TX];
      disTx      = wrLow && (address == `ADDR_CTRL) && writedata[`CTRL_DIS_TX];
      nodeIdZero = wrLow && (address == `ADDR_NODE_ID)
                   && (writedata[7:0] == `NODE_ID_ZERO);
   end

   // Mask and node ID registers
   always @(posedge clk) begin
      if (!rst_n) begin
         interrupt_mask_register <= `MASK_RESET;
         nodeId_q                <= `NODE_ID_RESET;
      end else begin
         if (wrLow && address == `ADDR_MASK)
            interrupt_mask_register <= writedata[7:0];
         if (wrLow && address == `ADDR_NODE_ID)
            nodeId_q <= writedata[7:0];
      end
   end

   // Status flags; status address itself ignores writes (R18)
   always @(posedge clk) begin
      if (!rst_n || softReset) begin
         status_q    <= `STATUS_RESET;                     // R19 R06 R01
         txPending_q <= 1'b0;
         ack_q       <= 1'b0;
      end else begin
         // Receive inhibit: event set wins over command clear while the flag is clear; once set, enable-receive clears it
         if (rxPacketStored && !status_q[`BIT_RI])
            status_q[`BIT_RI] <= 1'b1;                     // R01
         else if (enRx)
            status_q[`BIT_RI] <= 1'b0;                     // R02
         // Power-on flag
         if (nodeIdZero)
            status_q[`BIT_POR] <= 1'b1;                    // R06
         else if (clearFlags)
            status_q[`BIT_POR] <= 1'b0;                    // R07
         // Test bit held low
         status_q[`BIT_TEST] <= 1'b0;                      // R08
         status_q[6:5]       <= 2'b00;                     // R05
         // Reconfiguration flag
         if (idleExpired)
            status_q[`BIT_RECON] <= 1'b1;                  // R09
         else if (clearFlags)
            status_q[`BIT_RECON] <= 1'b0;                  // R10
         // Acknowledge is latched, shown once transmitter-available rises
         if (txPacketAcked && !txBroadcast && txPending_q)
            ack_q <= 1'b1;                                 // R12 R13
         else if (enTx)
            ack_q <= 1'b0;
         if (enTx)
            status_q[`BIT_TMA] <= 1'b0;                    // R14
         else if (txLastByteSent && txPending_q)
            status_q[`BIT_TMA] <= ack_q
                                  || (txPacketAcked && !txBroadcast); // R12 R13
         // Transmitter available
         if ((txLastByteSent && txPending_q) || disTx) begin
            status_q[`BIT_TA] <= 1'b1;                     // R15
            txPending_q       <= 1'b0;
         end else if (enTx) begin
            txPending_q       <= 1'b1;
         end else if (txPending_q && tokenReceived) begin
            status_q[`BIT_TA] <= 1'b0;                     // R16
         end
      end
   end

   // Masked flags
   assign intPending = status_q & interrupt_mask_register;

   // Interrupt and engine controls, registered
   always @(posedge clk) begin
      if (!rst_n) begin
         irq        <= 1'b0;
         rxNakReply <= 1'b0;
         rxEnabled  <= 1'b0;
         txEnabled  <= 1'b0;
      end else begin
         irq        <= intPending[`BIT_RI] || intPending[`BIT_RECON]
                       || intPending[`BIT_TA];             // R03 R11 R17
         rxNakReply <= rxIncomingRequest && status_q[`BIT_RI]; // R04
         rxEnabled  <= !status_q[`BIT_RI];
         txEnabled  <= txPending_q;
      end
   end

   // Read data and response, valid in the request cycle
   always @* begin
      readdata = `UNMAPPED_DATA;
      response = 2'h0;
      if (read) begin
         case (address)
            `ADDR_STATUS:  readdata = {24'h000000, status_q}; // R18
            `ADDR_MASK:    readdata = {24'h000000, interrupt_mask_register};
            `ADDR_CTRL:    readdata = `UNMAPPED_DATA;
            `ADDR_NODE_ID: readdata = {24'h000000, nodeId_q};
            default:       response = 2'h2;
         endcase
      end
   end
endmodule

// *** verilog/node_status_defines.vh ***
// Constants for the node status flag register block
`ifndef NODE_STATUS_DEFINES_VH
`define NODE_STATUS_DEFINES_VH

// Register word addresses (byte address = 4 * index)
`define ADDR_STATUS        4'h0
`define ADDR_MASK          4'h1
`define ADDR_CTRL          4'h2
`define ADDR_NODE_ID       4'h3
`define ADDR_ERR           4'h3
// Status bit positions
`define BIT_RI             7
`define BIT_POR            4
`define BIT_TEST           3
`define BIT_RECON          2
`define BIT_TMA            1
`define BIT_TA             0
// Reset values
`define STATUS_RESET       8'h91
`define MASK_RESET         8'h00
`define NODE_ID_RESET      8'h00
`define NODE_ID_ZERO       8'h00
// Control register bits (self-clearing command strobes)
`define CTRL_SOFT_RESET    0
`define CTRL_CLEAR_FLAGS   1
`define CTRL_EN_RX         2
`define CTRL_EN_TX         3
`define CTRL_DIS_TX        4
// Line idle time in microseconds and clock rate in MHz
`define IDLE_TIME_US       656
`define CLK_MHZ            20
// Read data for an unmapped address
`define UNMAPPED_DATA      32'h0000_0000

`endif

// *** verilog/idle_timer.v ***
// Line idle timer: pulses once when the receive line stays idle long enough
module idle_timer #(
   parameter CYCLES = 13120
) (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Line activity and count enable
   input  wire        lineActive,
   input  wire        enable,
   // Expiry pulse
   output reg         expired
);
   reg  [31:0] count_q;

   // Count idle cycles, restart on activity, fire once per idle stretch
   always @(posedge clk) begin
      if (!rst_n || lineActive || !enable) begin
         count_q <= 32'h0000_0000;
         expired <= 1'b0;
      end else begin
         expired <= (count_q == CYCLES - 1);
         if (count_q != CYCLES)
            count_q <= count_q + 32'h0000_0001;
      end
   end
endmodule

// *** bench/node_status_flags_assertions.sv ***
// Port-level checks for the node status flag block
module node_status_flags_assertions (
   // Clock, reset and bus
   input wire logic        clk, rst_n, read, write, waitrequest,
   input wire logic [3:0]  address, byteenable,
   input wire logic [31:0] writedata, readdata,
   input wire logic [1:0]  response,
   // Engine side and interrupt
   input wire logic        rxIncomingRequest, rxNakReply, rxEnabled, irq
);
   logic [7:0] maskQ;
   wire        stRd = read && address == 4'h0;
   wire        ctl  = write && address == 4'h2 && byteenable[0];
   // Shadow of the mask so interrupt level can be predicted
   always @(posedge clk) begin
      if (!rst_n) maskQ <= 8'h00;
      else if (write && address == 4'h1 && byteenable[0]) maskQ <= writedata[7:0];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_wait_low: assert property (!waitrequest)
      else $error("waitrequest raised");
   a_reserved_zero: assert property (stRd |-> readdata[31:8] == 24'h0 && readdata[6:5] == 2'h0 && !readdata[3])
      else $error("undefined or test bits set");
   a_unmapped_resp: assert property (read && address > 4'h3 |-> response == 2'h2 && readdata == 32'h0)
      else $error("unmapped read answered");
   a_irq_follow: assert property (stRd ##1 stRd && $stable(readdata) |-> irq == |(readdata[7:0] & maskQ))
      else $error("irq disagrees with flags");
   a_nak_cause: assert property (rxIncomingRequest |=> rxNakReply == !$past(rxEnabled))
      else $error("nak reply wrong");
   a_rx_arm: assert property (ctl && writedata[2] |-> ##[1:2] rxEnabled)
      else $error("receiver not armed");
   a_por_zero_id: assert property (write && address == 4'h3 && writedata[7:0] == 8'h00 ##1 stRd |-> readdata[4])
      else $error("power-on flag missing");
   a_clear_flags: assert property (ctl && writedata[1] ##1 stRd |-> readdata[4:2] == 3'h0)
      else $error("flags not cleared");
endmodule

// *** bench/net_engine_model.sv ***
// Receive and transmit engine model that raises event pulses
module net_engine_model (
   // Clock and one-hot request from the bench
   input  wire logic       clk,
   input  wire logic [4:0] evReq,
   // Single-cycle event pulses
   output logic            rxPacketStored, rxIncomingRequest, txPacketAcked,
   output logic            txLastByteSent, tokenReceived
);
   // Each request becomes one pulse a clock later; broadcast level is held by the bench
   always @(posedge clk) begin
      {tokenReceived, txLastByteSent, txPacketAcked, rxIncomingRequest, rxPacketStored} <= evReq;
   end
endmodule

// *** bench/node_status_flags_tb.sv ***
// Self-checking bench for the node status flag block
module node_status_flags_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_n = 0, read = 0, write = 0, receive_line_input = 1, txBroadcast = 0;
   logic [3:0]  address = 4'h0, byteenable = 4'hF;
   logic [31:0] writedata = 32'h0, rdQ;
   logic [1:0]  rsQ;
   logic [4:0]  evReq = 5'h0;
   wire [31:0]  readdata;
   wire [1:0]   response;
   wire         waitrequest, rxNakReply, rxEnabled, txEnabled, irq;
   wire         rxPacketStored, rxIncomingRequest, txPacketAcked, txLastByteSent, tokenReceived;
   int          errors = 0, cmp_count = 0, cycles = 0, nakCount = 0;
   initial forever #25 clk = ~clk;
   node_status_flags #(.IDLE_CYCLES(20)) node_status_flags_inst (.clk, .rst_n, .address, .read,
      .write, .writedata, .byteenable, .readdata, .waitrequest, .response, .receive_line_input,
      .rxPacketStored, .rxIncomingRequest, .txPacketAcked, .txBroadcast, .txLastByteSent,
      .tokenReceived, .rxNakReply, .rxEnabled, .txEnabled, .irq);
   net_engine_model net_engine_model_inst (.clk, .evReq, .rxPacketStored, .rxIncomingRequest,
      .txPacketAcked, .txLastByteSent, .tokenReceived);
   // Count nak replies and cut a hang short
   always @(posedge clk) begin
      if (rxNakReply === 1'b1) nakCount++;
      cycles++;
      if (cycles == 2000) begin
         errors++;
         $display("[ERR] %0t cycle limit reached", $time);
         print_verdict;
      end
   end
   task automatic chk(input logic [33:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= d;
      @(negedge clk);
      while (waitrequest !== 1'b0) @(negedge clk);
      rdQ = readdata;
      rsQ = response;
      @(posedge clk);
   endtask
   task automatic rel;
      read <= 0;
      write <= 0;
      @(posedge clk);
   endtask
   task automatic st(input logic [7:0] e);
      bus(0, 4'h0, 32'h0);
      bus(0, 4'h0, 32'h0);
      rel;
      chk({rsQ, rdQ}, {26'h0, e});
   endtask
   task automatic cmd(input logic [7:0] c, e);
      bus(1, 4'h2, {24'h0, c});
      st(e);
   endtask
   task automatic ev(input int i, input logic [7:0] e);
      evReq <= 5'h1 << i;
      @(posedge clk);
      evReq <= 5'h0;
      repeat (2) @(posedge clk);
      st(e);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      st(8'h91);
      bus(1, 4'h0, 32'h0); st(8'h91);
      bus(0, 4'h5, 32'h0); rel; chk({rsQ, rdQ}, {2'h2, 32'h0});
      bus(1, 4'h3, 32'h5); bus(1, 4'h1, 32'h85); bus(0, 4'h1, 32'h0); rel;
      chk({rsQ, rdQ}, 34'h85);
      chk({33'h0, irq}, 34'h1);
      $display("bus test done");
      cmd(8'h02, 8'h81);
      receive_line_input <= 0; repeat (30) @(posedge clk); st(8'h85);
      receive_line_input <= 1; cmd(8'h02, 8'h81);
      cmd(8'h04, 8'h01); ev(1, 8'h01); ev(0, 8'h81); ev(1, 8'h81);
      chk(34'(nakCount), 34'h1);
      $display("receive test done");
      cmd(8'h08, 8'h81); chk({33'h0, txEnabled}, 34'h1);
      ev(4, 8'h80); ev(2, 8'h80); ev(3, 8'h83);
      chk({33'h0, txEnabled}, 34'h0);
      cmd(8'h08, 8'h81); txBroadcast <= 1; ev(4, 8'h80);
      ev(2, 8'h80); ev(3, 8'h81); txBroadcast <= 0;
      cmd(8'h08, 8'h81); ev(4, 8'h80); cmd(8'h10, 8'h81);
      bus(1, 4'h3, 32'h0); st(8'h91); cmd(8'h02, 8'h81); cmd(8'h01, 8'h91);
      $display("transmit test done");
      print_verdict;
   end
endmodule
bind node_status_flags node_status_flags_assertions node_status_flags_assertions_inst (.clk,
   .rst_n, .read, .write, .waitrequest, .address, .byteenable, .writedata, .readdata, .response,
   .rxIncomingRequest, .rxNakReply, .rxEnabled, .irq);
